// *** dips_pkg.sv ***
// Constants for the display interrupt and pin selection register bank.
package dips_pkg;
	// Special-function register addresses on the core bus.
	localparam logic [7:0] SFR_IRQ_STATUS   = 8'hAE;
	localparam logic [7:0] SFR_SCAN_ON      = 8'hAF;
	localparam logic [7:0] SFR_IRQ_ENABLE   = 8'hE6;
	localparam logic [7:0] SFR_IRQ_FLAG     = 8'hF1;
	localparam logic [7:0] SFR_IRQ_PRIORITY = 8'hF6;
	// Secondary bus register addresses.
	localparam logic [7:0] SEC_COMMON_SEL   = 8'h23;
	localparam logic [7:0] SEC_SEGMENT_SEL  = 8'h24;
	// Field positions.
	localparam int LED_PEND_BIT    = 0;
	localparam int LCD_PEND_BIT    = 1;
	localparam int DISPLAY_IRQ_BIT = 6;
	localparam int COM_LO_TOP      = 3;
	localparam int COM_HI_BOT      = 4;
	// Implemented bits of the shared interrupt registers (7, 6, 4, 3, 2).
	localparam logic [7:0] IRQ_REG_MASK    = 8'hDC;
	// Reset values.
	localparam logic [7:0] RESET_BYTE      = 8'h00;
	localparam logic [7:0] READ_ZERO       = 8'h00;
	localparam logic [3:0] NIBBLE_ZERO     = 4'h0;
endpackage

// *** dips_top.sv ***
// Display interrupt bits and display pin selection registers.
module dips_top (
	input  wire logic       core_clk,
	input  wire logic       rst,
	input  wire logic       ce,
	input  wire logic [7:0] sfr_addr,
	input  wire logic       sfr_we,
	input  wire logic [7:0] sfr_wdata,
	output logic      [7:0] sfr_rdata_q,
	input  wire logic [7:0] sec_addr,
	input  wire logic       sec_we,
	input  wire logic [7:0] sec_wdata,
	output logic      [7:0] sec_rdata_q,
	input  wire logic       lcd_irq_event,
	input  wire logic       led_irq_event,
	input  wire logic       led_matrix_mode,
	input  wire logic       four_by_four_select,
	input  wire logic       high_current_sink_enable,
	output logic      [7:0] common_pin_q,
	output logic      [7:0] matrix_segment_pin_q,
	output logic      [7:0] sink_pin_q,
	output logic      [7:0] segment_pin_q,
	output logic            irq_request_q,
	output logic            irq_high_priority_q
);
	logic       lcd_irq_pending_q;
	logic       led_irq_pending_q;
	logic [7:0] irq_enable_one_q;
	logic [7:0] irq_flag_one_q;
	logic [7:0] irq_priority_one_q;
	logic [7:0] common_line_select_q;
	logic [7:0] segment_line_select_q;
	logic       wr_status;
	logic       wr_scan_on;
	logic       wr_enable;
	logic       wr_flag;
	logic       wr_priority;
	logic       display_irq_enable;
	logic       display_irq_flag;
	logic       display_irq_priority;

	// Write decodes; every effect below is also gated by the clock enable.
	assign wr_status   = ce && sfr_we && (sfr_addr == dips_pkg::SFR_IRQ_STATUS);
	assign wr_scan_on  = ce && sfr_we && (sfr_addr == dips_pkg::SFR_SCAN_ON);
	assign wr_enable   = ce && sfr_we && (sfr_addr == dips_pkg::SFR_IRQ_ENABLE);
	assign wr_flag     = ce && sfr_we && (sfr_addr == dips_pkg::SFR_IRQ_FLAG);
	assign wr_priority = ce && sfr_we && (sfr_addr == dips_pkg::SFR_IRQ_PRIORITY);

	// Named views of the shared interrupt bits.
	assign display_irq_enable   = irq_enable_one_q[dips_pkg::DISPLAY_IRQ_BIT];
	assign display_irq_flag     = irq_flag_one_q[dips_pkg::DISPLAY_IRQ_BIT];
	assign display_irq_priority = irq_priority_one_q[dips_pkg::DISPLAY_IRQ_BIT];

	// LCD pending bit; a new event wins over a clear in the same cycle so none is lost.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			lcd_irq_pending_q <= 1'b0;
		end else if (ce) begin
			if (lcd_irq_event) begin
				lcd_irq_pending_q <= 1'b1;
			end else if (wr_scan_on) begin
				lcd_irq_pending_q <= 1'b0;
			end else if (wr_status && !sfr_wdata[dips_pkg::LCD_PEND_BIT]) begin
				lcd_irq_pending_q <= 1'b0;
			end
		end
	end

	// LED pending bit, cleared by writing 0 like its LCD neighbour.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			led_irq_pending_q <= 1'b0;
		end else if (ce) begin
			if (led_irq_event) begin
				led_irq_pending_q <= 1'b1;
			end else if (wr_status && !sfr_wdata[dips_pkg::LED_PEND_BIT]) begin
				led_irq_pending_q <= 1'b0;
			end
		end
	end

	// Enable and priority registers hold only their implemented bits.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			irq_enable_one_q   <= dips_pkg::RESET_BYTE;
			irq_priority_one_q <= dips_pkg::RESET_BYTE;
		end else begin
			if (wr_enable) begin
				irq_enable_one_q <= sfr_wdata & dips_pkg::IRQ_REG_MASK;
			end
			if (wr_priority) begin
				irq_priority_one_q <= sfr_wdata & dips_pkg::IRQ_REG_MASK;
			end
		end
	end

	// Flag register; either display event sets bit 6 and beats a software clear.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			irq_flag_one_q <= dips_pkg::RESET_BYTE;
		end else if (ce) begin
			if (wr_flag) begin
				irq_flag_one_q <= sfr_wdata & dips_pkg::IRQ_REG_MASK;
			end
			if (lcd_irq_event || led_irq_event) begin
				irq_flag_one_q[dips_pkg::DISPLAY_IRQ_BIT] <= 1'b1;
			end
		end
	end

	// Interrupt request to the core, one cycle behind the flag and enable.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			irq_request_q       <= 1'b0;
			irq_high_priority_q <= 1'b0;
		end else if (ce) begin
			irq_request_q       <= display_irq_flag && display_irq_enable;
			irq_high_priority_q <= display_irq_priority;
		end
	end

	// Pin selection registers on the secondary bus; both start as general I/O.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			common_line_select_q  <= dips_pkg::RESET_BYTE;
			segment_line_select_q <= dips_pkg::RESET_BYTE;
		end else if (ce && sec_we) begin
			if (sec_addr == dips_pkg::SEC_COMMON_SEL) begin
				common_line_select_q <= sec_wdata;
			end
			if (sec_addr == dips_pkg::SEC_SEGMENT_SEL) begin
				segment_line_select_q <= sec_wdata;
			end
		end
	end

	// Pin functions. Sink mode wins outright, since the scan setup is then meaningless.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			common_pin_q         <= dips_pkg::RESET_BYTE;
			matrix_segment_pin_q <= dips_pkg::RESET_BYTE;
			sink_pin_q           <= dips_pkg::RESET_BYTE;
			segment_pin_q        <= dips_pkg::RESET_BYTE;
		end else if (ce) begin
			if (high_current_sink_enable) begin
				sink_pin_q           <= common_line_select_q;
				common_pin_q         <= dips_pkg::RESET_BYTE;
				matrix_segment_pin_q <= dips_pkg::RESET_BYTE;
				segment_pin_q        <= dips_pkg::RESET_BYTE;
			end else begin
				sink_pin_q    <= dips_pkg::RESET_BYTE;
				segment_pin_q <= segment_line_select_q;
				if (!led_matrix_mode) begin
					common_pin_q         <= dips_pkg::RESET_BYTE;
					matrix_segment_pin_q <= dips_pkg::RESET_BYTE;
				end else if (four_by_four_select) begin
					common_pin_q <= {dips_pkg::NIBBLE_ZERO,
						common_line_select_q[dips_pkg::COM_LO_TOP:0]};
					matrix_segment_pin_q <= {common_line_select_q[7:dips_pkg::COM_HI_BOT],
						dips_pkg::NIBBLE_ZERO};
				end else begin
					common_pin_q         <= common_line_select_q;
					matrix_segment_pin_q <= dips_pkg::RESET_BYTE;
				end
			end
		end
	end

	// Registered read data; unmapped addresses read zero.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			sfr_rdata_q <= dips_pkg::READ_ZERO;
			sec_rdata_q <= dips_pkg::READ_ZERO;
		end else if (ce) begin
			case (sfr_addr)
				dips_pkg::SFR_IRQ_STATUS: begin
					sfr_rdata_q <= {6'h00, lcd_irq_pending_q, led_irq_pending_q};
				end
				dips_pkg::SFR_IRQ_ENABLE: begin
					sfr_rdata_q <= irq_enable_one_q;
				end
				dips_pkg::SFR_IRQ_FLAG: begin
					sfr_rdata_q <= irq_flag_one_q;
				end
				dips_pkg::SFR_IRQ_PRIORITY: begin
					sfr_rdata_q <= irq_priority_one_q;
				end
				default: begin
					sfr_rdata_q <= dips_pkg::READ_ZERO;
				end
			endcase
			case (sec_addr)
				dips_pkg::SEC_COMMON_SEL: begin
					sec_rdata_q <= common_line_select_q;
				end
				dips_pkg::SEC_SEGMENT_SEL: begin
					sec_rdata_q <= segment_line_select_q;
				end
				default: begin
					sec_rdata_q <= dips_pkg::READ_ZERO;
				end
			endcase
		end
	end

	// Checks on the behaviour above.
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	property p_lcd_clear_write;
		wr_status && !sfr_wdata[dips_pkg::LCD_PEND_BIT] && !lcd_irq_event |=> !lcd_irq_pending_q;
	endproperty
	a_lcd_clear_write: assert property (p_lcd_clear_write) else $error("lcd pending not cleared");

	property p_lcd_clear_scan;
		wr_scan_on && !lcd_irq_event |=> !lcd_irq_pending_q;
	endproperty
	a_lcd_clear_scan: assert property (p_lcd_clear_scan) else $error("scan-on did not clear");

	property p_lcd_set_wins;
		ce && lcd_irq_event |=> lcd_irq_pending_q && display_irq_flag;
	endproperty
	a_lcd_set_wins: assert property (p_lcd_set_wins) else $error("lcd event lost");

	property p_flag_clear;
		wr_flag && !sfr_wdata[dips_pkg::DISPLAY_IRQ_BIT] && !lcd_irq_event && !led_irq_event
			|=> !display_irq_flag;
	endproperty
	a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

	property p_request_gate;
		ce |=> irq_request_q == ($past(display_irq_flag) && $past(display_irq_enable));
	endproperty
	a_request_gate: assert property (p_request_gate) else $error("request gate wrong");

	property p_priority_level;
		wr_priority ##1 ce |=> irq_high_priority_q == $past(sfr_wdata[dips_pkg::DISPLAY_IRQ_BIT], 2);
	endproperty
	a_priority_level: assert property (p_priority_level) else $error("priority wrong");

	property p_no_request_disabled;
		!display_irq_enable ##1 ce && !display_irq_enable |=> !irq_request_q;
	endproperty
	a_no_request_disabled: assert property (p_no_request_disabled) else $error("disabled request");

	property p_sink_mode;
		ce && high_current_sink_enable |=> sink_pin_q == $past(common_line_select_q)
			&& common_pin_q == dips_pkg::RESET_BYTE && segment_pin_q == dips_pkg::RESET_BYTE;
	endproperty
	a_sink_mode: assert property (p_sink_mode) else $error("sink mode pins wrong");

	property p_four_split;
		ce && !high_current_sink_enable && led_matrix_mode && four_by_four_select
			|=> matrix_segment_pin_q[7:4] == $past(common_line_select_q[7:4])
			&& common_pin_q[7:4] == dips_pkg::NIBBLE_ZERO;
	endproperty
	a_four_split: assert property (p_four_split) else $error("four by four split wrong");

	property p_plain_common;
		ce && !high_current_sink_enable && led_matrix_mode && !four_by_four_select
			|=> common_pin_q == $past(common_line_select_q);
	endproperty
	a_plain_common: assert property (p_plain_common) else $error("common pins wrong");

	property p_segment_pins;
		ce && !high_current_sink_enable |=> segment_pin_q == $past(segment_line_select_q);
	endproperty
	a_segment_pins: assert property (p_segment_pins) else $error("segment pins wrong");

	c_request: cover property (lcd_irq_event ##1 display_irq_enable ##1 irq_request_q);
	c_scan_clear: cover property (lcd_irq_pending_q ##1 wr_scan_on);
	c_four_mode: cover property (four_by_four_select && led_matrix_mode && |common_line_select_q);
	c_sink_mode: cover property (high_current_sink_enable && |sink_pin_q);
endmodule

// *** tb.sv ***
// Self-checking testbench for the display interrupt and pin selection register bank.
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic       core_clk;
	logic       rst;
	logic       ce;
	logic [7:0] sfr_addr;
	logic       sfr_we;
	logic [7:0] sfr_wdata;
	logic [7:0] sfr_rdata_q;
	logic [7:0] sec_addr;
	logic       sec_we;
	logic [7:0] sec_wdata;
	logic [7:0] sec_rdata_q;
	logic       lcd_irq_event;
	logic       led_irq_event;
	logic       led_matrix_mode;
	logic       four_by_four_select;
	logic       high_current_sink_enable;
	logic [7:0] common_pin_q;
	logic [7:0] matrix_segment_pin_q;
	logic [7:0] sink_pin_q;
	logic [7:0] segment_pin_q;
	logic       irq_request_q;
	logic       irq_high_priority_q;
	int         fail_count;
	int         samples_checked;

	dips_top dut (.core_clk(core_clk), .rst(rst), .ce(ce),
		.sfr_addr(sfr_addr), .sfr_we(sfr_we), .sfr_wdata(sfr_wdata), .sfr_rdata_q(sfr_rdata_q),
		.sec_addr(sec_addr), .sec_we(sec_we), .sec_wdata(sec_wdata), .sec_rdata_q(sec_rdata_q),
		.lcd_irq_event(lcd_irq_event), .led_irq_event(led_irq_event),
		.led_matrix_mode(led_matrix_mode), .four_by_four_select(four_by_four_select),
		.high_current_sink_enable(high_current_sink_enable), .common_pin_q(common_pin_q),
		.matrix_segment_pin_q(matrix_segment_pin_q), .sink_pin_q(sink_pin_q),
		.segment_pin_q(segment_pin_q), .irq_request_q(irq_request_q),
		.irq_high_priority_q(irq_high_priority_q));

	// Free-running core clock at 50 ns.
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end

	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp) begin
			$display("[ERR] %s expected %h seen %h", name, exp, got);
			fail_count++;
		end
	endtask

	// One write cycle; the strobe drops at the taking edge so back-to-back calls stay legal.
	task automatic wr(input logic sec, input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		sfr_addr <= a;
		sec_addr <= a;
		sfr_wdata <= d;
		sec_wdata <= d;
		sfr_we <= ~sec;
		sec_we <= sec;
		@(posedge core_clk);
		sfr_we <= 1'b0;
		sec_we <= 1'b0;
	endtask

	// Read data is registered, so it is sampled one edge after the address goes out.
	task automatic rchk(input logic sec, input logic [7:0] a, input logic [7:0] exp);
		@(posedge core_clk);
		sfr_addr <= a;
		sec_addr <= a;
		@(posedge core_clk);
		#1;
		chk($sformatf("read %h", a), exp, sec ? sec_rdata_q : sfr_rdata_q);
	endtask

	// Pins and the request trail a register change by one extra cycle; three edges cover it.
	task automatic settle;
		repeat (3) @(posedge core_clk);
		#1;
	endtask

	task automatic pulse(input logic lcd, input logic led);
		@(posedge core_clk);
		lcd_irq_event <= lcd;
		led_irq_event <= led;
		@(posedge core_clk);
		lcd_irq_event <= 1'b0;
		led_irq_event <= 1'b0;
		settle();
	endtask

	task automatic pins(input logic lm, input logic ff, input logic sk, input logic [31:0] exp);
		@(posedge core_clk);
		led_matrix_mode <= lm;
		four_by_four_select <= ff;
		high_current_sink_enable <= sk;
		settle();
		chk("common", exp[31:24], common_pin_q);
		chk("matseg", exp[23:16], matrix_segment_pin_q);
		chk("sink", exp[15:8], sink_pin_q);
		chk("segment", exp[7:0], segment_pin_q);
	endtask

	task automatic t_reset;
		logic [7:0] regs [4] = '{8'hAE, 8'hE6, 8'hF1, 8'hF6};
		foreach (regs[i]) rchk(1'b0, regs[i], 8'h00);
		rchk(1'b1, dips_pkg::SEC_COMMON_SEL, 8'h00);
		rchk(1'b1, dips_pkg::SEC_SEGMENT_SEL, 8'h00);
		pins(1'b1, 1'b0, 1'b0, 32'h0000_0000);
	endtask

	task automatic t_regs;
		wr(1'b0, 8'hE6, 8'hFF);
		rchk(1'b0, 8'hE6, dips_pkg::IRQ_REG_MASK);
		wr(1'b0, 8'hF6, 8'hFF);
		rchk(1'b0, 8'hF6, dips_pkg::IRQ_REG_MASK);
		wr(1'b0, 8'hE6, 8'h00);
		wr(1'b0, 8'hF6, 8'h00);
		wr(1'b0, 8'h55, 8'hFF);
		rchk(1'b0, 8'h55, 8'h00);
		rchk(1'b0, 8'hAF, 8'h00);
		wr(1'b1, 8'h23, 8'hA5);
		rchk(1'b1, 8'h23, 8'hA5);
		wr(1'b1, 8'h24, 8'h5A);
		rchk(1'b1, 8'h24, 8'h5A);
		rchk(1'b1, 8'h25, 8'h00);
		// A write while the clock enable is low must leave the register alone.
		@(posedge core_clk);
		ce <= 1'b0;
		wr(1'b1, 8'h23, 8'hFF);
		ce <= 1'b1;
		rchk(1'b1, 8'h23, 8'hA5);
	endtask

	task automatic t_irq;
		wr(1'b0, 8'hE6, 8'h40);
		pulse(1'b1, 1'b0);
		rchk(1'b0, 8'hAE, 8'h02);
		rchk(1'b0, 8'hF1, 8'h40);
		chk("request", 8'h01, {7'h00, irq_request_q});
		chk("priority", 8'h00, {7'h00, irq_high_priority_q});
		wr(1'b0, 8'hF6, 8'h40);
		settle();
		chk("priority", 8'h01, {7'h00, irq_high_priority_q});
		wr(1'b0, 8'hAE, 8'h00);
		rchk(1'b0, 8'hAE, 8'h00);
		pulse(1'b1, 1'b0);
		wr(1'b0, 8'hAF, 8'h01);
		rchk(1'b0, 8'hAE, 8'h00);
		wr(1'b0, 8'hF1, 8'h00);
		settle();
		chk("request", 8'h00, {7'h00, irq_request_q});
		rchk(1'b0, 8'hF1, 8'h00);
		wr(1'b0, 8'hE6, 8'h00);
		pulse(1'b0, 1'b1);
		rchk(1'b0, 8'hF1, 8'h40);
		rchk(1'b0, 8'hAE, 8'h01);
		chk("request", 8'h00, {7'h00, irq_request_q});
		wr(1'b0, 8'hE6, 8'h40);
		settle();
		chk("request", 8'h01, {7'h00, irq_request_q});
		wr(1'b0, 8'hF1, 8'h00);
		wr(1'b0, 8'hAE, 8'h00);
		wr(1'b0, 8'hF6, 8'h00);
	endtask

	// An event in the same cycle as a software clear must survive; software may also raise the flag.
	task automatic t_race;
		@(posedge core_clk);
		sfr_addr <= dips_pkg::SFR_IRQ_STATUS;
		sfr_wdata <= 8'h00;
		sfr_we <= 1'b1;
		lcd_irq_event <= 1'b1;
		@(posedge core_clk);
		sfr_we <= 1'b0;
		lcd_irq_event <= 1'b0;
		rchk(1'b0, dips_pkg::SFR_IRQ_STATUS, 8'h02);
		rchk(1'b0, dips_pkg::SFR_IRQ_FLAG, 8'h40);
		wr(1'b0, dips_pkg::SFR_IRQ_FLAG, 8'h00);
		wr(1'b0, dips_pkg::SFR_IRQ_STATUS, 8'h00);
		rchk(1'b0, dips_pkg::SFR_IRQ_STATUS, 8'h00);
		settle();
		chk("request", 8'h00, {7'h00, irq_request_q});
		wr(1'b0, dips_pkg::SFR_IRQ_FLAG, 8'h40);
		settle();
		chk("request", 8'h01, {7'h00, irq_request_q});
		wr(1'b0, dips_pkg::SFR_IRQ_FLAG, 8'h00);
		rchk(1'b0, dips_pkg::SFR_IRQ_FLAG, 8'h00);
	endtask

	// Common select A5 and segment select 3C give distinct patterns in every mode.
	task automatic t_pins;
		wr(1'b1, 8'h23, 8'hA5);
		wr(1'b1, 8'h24, 8'h3C);
		pins(1'b1, 1'b0, 1'b0, 32'hA500_003C);
		pins(1'b1, 1'b1, 1'b0, 32'h05A0_003C);
		pins(1'b1, 1'b0, 1'b1, 32'h0000_A500);
		pins(1'b0, 1'b1, 1'b0, 32'h0000_003C);
		wr(1'b1, 8'h24, 8'h00);
		pins(1'b1, 1'b0, 1'b0, 32'hA500_0000);
		pins(1'b1, 1'b1, 1'b1, 32'h0000_A500);
	endtask

	task automatic stop_test;
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Watchdog sized well above the roughly 180 cycles the sequence needs.
	initial begin
		repeat (5000) @(posedge core_clk);
		fail_count++;
		stop_test();
	end

	// Main sequence: idle inputs at time zero, 16 cycles of reset, then the scenarios.
	initial begin
		fail_count = 0;
		samples_checked = 0;
		rst = 1'b1;
		ce = 1'b1;
		sfr_addr = 8'h00;
		sfr_we = 1'b0;
		sfr_wdata = 8'h00;
		sec_addr = 8'h00;
		sec_we = 1'b0;
		sec_wdata = 8'h00;
		lcd_irq_event = 1'b0;
		led_irq_event = 1'b0;
		led_matrix_mode = 1'b1;
		four_by_four_select = 1'b0;
		high_current_sink_enable = 1'b0;
		repeat (16) @(posedge core_clk);
		rst <= 1'b0;
		t_reset();
		t_regs();
		t_irq();
		t_race();
		t_pins();
		stop_test();
	end
endmodule
